// [src/kli_pkg.sv]
// constants for the keypad level interrupt block
package kli_pkg;
  localparam logic [7:0] KEYPAD_CONTROL_ADDR = 8'ha3;
  localparam logic [7:0] KEYPAD_STATUS_ADDR = 8'ha4;
  localparam logic [7:0] KEYPAD_CONTROL_RESET = 8'h0f;
  localparam logic [7:0] KEYPAD_STATUS_RESET = 8'h00;
  localparam int LEVEL_SELECT_LSB = 4;
  localparam int FLAG_MASK_LSB = 0;
  localparam int DETECT_FLAGS_LSB = 0;
  localparam int WAKE_ENABLE_BIT = 7;
  localparam int NUM_INPUTS = 4;
  localparam int SYNC_STAGES = 2;
endpackage

// [src/kli_sync.sv]
// two flip-flop synchroniser for the keypad pins
`timescale 1ns/1ns
`default_nettype none
module kli_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // reset to the pins' idle level, not to a level that could match
      meta <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// [src/kli_keypad.sv]
// keypad level interrupt block with its two special function registers
`timescale 1ns/1ns
`default_nettype none
module kli_keypad #(
  parameter int N_IN = kli_pkg::NUM_INPUTS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [N_IN-1:0] port_one_low_pins,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic keypad_irq_global_enable,
  input wire logic cpu_in_idle,
  input wire logic cpu_in_powerdown,
  output logic [7:0] sfr_rdata,
  output logic keypad_irq,
  output logic idle_wake,
  output logic powerdown_wake
);
  // pin level that matches nothing under the reset level select
  localparam logic [N_IN-1:0] PIN_IDLE =
    N_IN'(~kli_pkg::KEYPAD_CONTROL_RESET[
      kli_pkg::LEVEL_SELECT_LSB +: kli_pkg::NUM_INPUTS]);

  logic [N_IN-1:0] keypad_inputs;
  logic [N_IN-1:0] input_level_select;
  logic [N_IN-1:0] input_flag_mask;
  logic [N_IN-1:0] input_detect_flags;
  logic [N_IN-1:0] next_flags;
  logic [N_IN-1:0] level_match;
  logic powerdown_wake_enable;
  logic any_request;
  logic control_write;
  logic status_write;
  logic status_read;
  logic [7:0] next_rdata;

  // address decode, shared by the write, read and clear paths
  function automatic logic hits_control(input logic [7:0] addr);
    return addr == kli_pkg::KEYPAD_CONTROL_ADDR;
  endfunction

  function automatic logic hits_status(input logic [7:0] addr);
    return addr == kli_pkg::KEYPAD_STATUS_ADDR;
  endfunction

  // polarity compare: xnor with the level select
  function automatic logic [N_IN-1:0] level_hits(
    input logic [N_IN-1:0] pins,
    input logic [N_IN-1:0] level
  );
    return ~(pins ^ level);
  endfunction

  function automatic logic [7:0] pack_control(
    input logic [N_IN-1:0] level,
    input logic [N_IN-1:0] mask
  );
    logic [7:0] word;
    word = 8'h00;
    word[kli_pkg::LEVEL_SELECT_LSB +: N_IN] = level;
    word[kli_pkg::FLAG_MASK_LSB +: N_IN] = mask;
    return word;
  endfunction

  // reserved bits 6..4 stay zero
  function automatic logic [7:0] pack_status(
    input logic [N_IN-1:0] flags,
    input logic wake_enable
  );
    logic [7:0] word;
    word = 8'h00;
    word[kli_pkg::DETECT_FLAGS_LSB +: N_IN] = flags;
    word[kli_pkg::WAKE_ENABLE_BIT] = wake_enable;
    return word;
  endfunction

  // chain starts at the idle level so reset raises no false flag
  kli_sync #(
    .WIDTH(N_IN),
    .RESET_VALUE(PIN_IDLE)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(port_one_low_pins),
    .sync_out(keypad_inputs)
  );

  assign level_match = level_hits(keypad_inputs, input_level_select);
  assign control_write = sfr_wr && hits_control(sfr_addr);
  assign status_write = sfr_wr && hits_status(sfr_addr);
  assign status_read = sfr_rd && hits_status(sfr_addr);

  // one request line for all four sources
  assign any_request = |(input_detect_flags & ~input_flag_mask);

  // level select and mask
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      input_level_select <= kli_pkg::KEYPAD_CONTROL_RESET[
        kli_pkg::LEVEL_SELECT_LSB +: kli_pkg::NUM_INPUTS];
      input_flag_mask <= kli_pkg::KEYPAD_CONTROL_RESET[
        kli_pkg::FLAG_MASK_LSB +: kli_pkg::NUM_INPUTS];
    end else if (control_write) begin
      input_level_select <= sfr_wdata[kli_pkg::LEVEL_SELECT_LSB +: N_IN];
      input_flag_mask <= sfr_wdata[kli_pkg::FLAG_MASK_LSB +: N_IN];
    end
  end

  // flags are hardware set only; writes touch the wake enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      powerdown_wake_enable <= kli_pkg::KEYPAD_STATUS_RESET[
        kli_pkg::WAKE_ENABLE_BIT];
    end else if (status_write) begin
      powerdown_wake_enable <= sfr_wdata[kli_pkg::WAKE_ENABLE_BIT];
    end
  end

  // a level present in the read cycle re-sets the flag: set wins
  always_comb begin
    next_flags = input_detect_flags | level_match;
    if (status_read) begin
      next_flags = level_match;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      input_detect_flags <= kli_pkg::KEYPAD_STATUS_RESET[
        kli_pkg::DETECT_FLAGS_LSB +: kli_pkg::NUM_INPUTS];
    end else begin
      input_detect_flags <= next_flags;
    end
  end

  // read data is zero outside a read, so the bus can be or-ed
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_rd && hits_control(sfr_addr)) begin
      next_rdata = pack_control(input_level_select, input_flag_mask);
    end else if (sfr_rd && hits_status(sfr_addr)) begin
      next_rdata = pack_status(input_detect_flags, powerdown_wake_enable);
    end
  end

  // registered outputs; one cycle behind the flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      keypad_irq <= 1'b0;
    end else begin
      keypad_irq <= any_request && keypad_irq_global_enable;
    end
  end

  // idle exit needs no enable of its own
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_wake <= 1'b0;
    end else begin
      idle_wake <= any_request && cpu_in_idle;
    end
  end

  // spurious wakes are left to software to screen
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      powerdown_wake <= 1'b0;
    end else begin
      powerdown_wake <= any_request && cpu_in_powerdown
        && powerdown_wake_enable;
    end
  end
endmodule
`default_nettype wire

// [dv/kli_keypad_asserts.sv]
// keypad port checker
`timescale 1ns/1ns
`default_nettype none
module kli_keypad_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] port_one_low_pins,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic keypad_irq_global_enable,
  input wire logic cpu_in_idle,
  input wire logic cpu_in_powerdown,
  input wire logic [7:0] sfr_rdata,
  input wire logic keypad_irq,
  input wire logic idle_wake,
  input wire logic powerdown_wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_en;
    keypad_irq |-> $past(keypad_irq_global_enable);
  endproperty
  a_en: assert property (p_en) else $error("irq while disabled");
  property p_idle;
    idle_wake |-> $past(cpu_in_idle);
  endproperty
  a_idle: assert property (p_idle) else $error("idle wake");
  property p_pd;
    powerdown_wake |-> $past(cpu_in_powerdown);
  endproperty
  a_pd: assert property (p_pd) else $error("powerdown wake");
  property p_shared;
    keypad_irq |-> idle_wake == $past(cpu_in_idle);
  endproperty
  a_shared: assert property (p_shared) else $error("shared request");
  property p_rsv;
    $past(sfr_rd) && $past(sfr_addr) == kli_pkg::KEYPAD_STATUS_ADDR
      |-> sfr_rdata[6:4] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_quiet;
    !$past(sfr_rd) |-> sfr_rdata == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data idle");
  property p_unmapped;
    $past(sfr_rd) && $past(sfr_addr) != kli_pkg::KEYPAD_STATUS_ADDR
      && $past(sfr_addr) != kli_pkg::KEYPAD_CONTROL_ADDR
      |-> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
endmodule
bind kli_keypad kli_keypad_asserts i_kli_keypad_asserts (.*);
`default_nettype wire

// [dv/kli_matrix.sv]
// key matrix model
`timescale 1ns/1ns
`default_nettype none
module kli_matrix (input wire logic [3:0] pressed, input wire logic hi,
  output logic [3:0] pins);
  assign pins = hi ? pressed : ~pressed; // idle keys never match
endmodule
`default_nettype wire

// [dv/tb_kli_keypad.sv]
// keypad bench
`timescale 1ns/1ns
`default_nettype none
module tb_kli_keypad;
  logic clk = 0, resetn = 0, rd = 0, wr = 0, en = 0, idl = 0, pd = 0, lvl = 0;
  logic [7:0] addr = 8'h0, wd = 8'h0, rdata;
  logic [3:0] key = 4'h0, pins, m, p;
  logic irq, iw, pw, kp;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (++cyc == 20000) stop_test(1);
  kli_matrix i_kli_matrix (.pressed(key), .hi(lvl), .pins);
  kli_keypad i_kli_keypad (.clk, .resetn, .port_one_low_pins(pins),
    .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd),
    .keypad_irq_global_enable(en), .cpu_in_idle(idl), .cpu_in_powerdown(pd),
    .sfr_rdata(rdata), .keypad_irq(irq), .idle_wake(iw), .powerdown_wake(pw));
  task chk(input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) mismatches++;
    if (s !== e) $display("ERROR %0t %h %h", $time, s, e);
  endtask
  task acc(input logic w, input logic [7:0] a, v, k = 8'hff);
    @(posedge clk) {wr, rd, addr, wd} <= {w, !w, a, v};
    @(posedge clk) {wr, rd} <= 2'h0;
    #1 if (!w) chk(rdata & k, v);
  endtask
  function logic [7:0] want();
    return {5'h0, {3{|(p & ~m)}} & {en, idl, pd & kp}};
  endfunction
  task stop_test(input int t);
    $display("counts %0d %0d", mismatches + t, cmp_count);
    if (mismatches + t == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h5a2068eb));
    repeat (3) @(posedge clk);
    resetn <= 1;
    acc(0, 8'ha3, 8'h0f);
    acc(0, 8'ha4, 8'h0);
    repeat (60) begin
      {lvl, kp, m, p} = 10'($urandom);
      @(posedge clk) {en, idl, pd} <= 3'($urandom);
      acc(1, 8'ha3, {{4{lvl}}, m});
      acc(1, 8'ha4, {kp, 7'h0});
      // polarity swap may leave stray flags, so only bits 7..4 are judged
      acc(0, 8'ha4, {kp, 7'h0}, 8'hf0);
      @(posedge clk) key <= p;
      #51 chk({5'h0, irq, iw, pw}, want());
      @(posedge clk) key <= 4'h0;
      repeat (4) @(posedge clk);
      acc(0, 8'ha4, {kp, 3'h0, p});
      acc(0, 8'ha4, {kp, 7'h0});
      acc(0, 8'ha5, 8'h00);
    end
    stop_test(0);
  end
endmodule
`default_nettype wire
